// [pkg/bcs_pkg.sv]
// bcs_pkg: offsets, field positions, reset values, timing and carrier types
// for the booster control and status register bank.
// assumes a 100 MHz core clock.
package bcs_pkg;

	// register offsets
	localparam logic [7:0] OFS_STATUS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_RUN_COMMAND = 8'h08;
	localparam logic [7:0] OFS_OUTPUT_AND_CHARGE_END_LEVELS = 8'h09;
	localparam logic [7:0] OFS_BATTERY_FLOOR_SETTING = 8'h0a;
	localparam logic [7:0] OFS_AUTO_RUN_SETTING = 8'h0b;
	localparam logic [7:0] OFS_STORAGE_CEILING_SETTING = 8'h0c;

	// status field positions
	localparam int STS_BATT_FLOOR_BIT = 7;
	localparam int STS_CAP_WARN_BIT = 6;
	localparam int STS_OUT_ALARM_BIT = 5;
	localparam int STS_READY_BIT = 0;

	// command field positions
	localparam int CMD_ON_DEMAND_BIT = 0;
	localparam int CMD_CONTINUOUS_BIT = 1;
	localparam int CMD_FORCE_ACTIVE_BIT = 2;
	localparam int CMD_OPT_RESET_BIT = 3;

	// settings field positions
	localparam int VSET_LSB = 0;
	localparam int VFIX_LSB = 4;
	localparam int VMIN_LSB = 0;
	localparam int AUTO_RUN_BIT = 7;
	localparam int CEILING_BIT = 4;

	// values after reset, and the optimizer slot that selects the fixed code
	localparam logic [3:0] VSET_RESET = 4'h9;
	localparam logic [3:0] VFIX_RESET = 4'h0;
	localparam logic [2:0] VMIN_RESET = 3'h0;
	localparam logic CEILING_RESET = 1'b0;
	localparam logic [3:0] FIXED_SLOT = 4'h0;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_EW_NS = 1000;
	localparam int T_EW_CYCLES = (T_EW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_SETTLE_CYCLES = 3;

	// strap capture sequence
	typedef enum logic [1:0] {
		BCS_STRAP_WAIT = 2'b01,
		BCS_STRAP_DONE = 2'b10
	} bcs_strap_t;

	// programmed levels and run controls passed to the converter logic
	typedef struct packed {
		logic [3:0] vset;
		logic [3:0] vfix;
		logic [2:0] vmin;
		logic ceiling_high;
		logic auto_run;
		logic on_demand;
		logic continuous;
		logic force_active;
	} bcs_levels_t;

	// analog comparator results, already synchronised
	typedef struct packed {
		logic batt_below_floor;
		logic cap_below_warn;
		logic out_below_set;
	} bcs_cmp_t;

	// state of the register bank, apart from the synchroniser and pulse timer
	typedef struct packed {
		bcs_levels_t lv;
		logic batt_floor_flag;
		logic cap_warn_flag;
		logic out_alarm_flag;
		logic cap_below_d;
		logic opt_reset_pulse;
		logic [7:0] rdata;
		bcs_strap_t strap;
		logic [1:0] strap_cnt;
	} bcs_state_t;

endpackage

// [hw/bcs_sync2.sv]
// bcs_sync2: two flip-flop synchroniser for a vector of slow levels.
// assumes every bit is an independent level, not a coded word.
`timescale 1ns/1ns
module bcs_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk, // core clock
	input wire logic reset, // synchronous reset, active high
	input wire logic [WIDTH-1:0] async_in, // levels from outside the domain
	output logic [WIDTH-1:0] sync_out // synchronised levels
);
	logic [WIDTH-1:0] stage1_r;

	initial begin
		if (WIDTH < 1)
			$error("bcs_sync2: WIDTH must be at least 1");
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stage1_r <= '0;
			sync_out <= '0;
		end else begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule

// [hw/bcs_pulse_timer.sv]
// bcs_pulse_timer: holds an active-high window for a fixed number of cycles
// after each start pulse; a new start restarts the window.
// assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ns
module bcs_pulse_timer #(
	parameter int CYCLES = bcs_pkg::T_EW_CYCLES
) (
	input wire logic core_clk, // core clock
	input wire logic reset, // synchronous reset, active high
	input wire logic start, // one-cycle start pulse
	output logic busy // high for CYCLES cycles after start
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;

	initial begin
		if (CYCLES < 1)
			$error("bcs_pulse_timer: CYCLES must be at least 1");
	end

	always_comb begin
		count_nxt = count_r;
		if (start)
			count_nxt = CW'(CYCLES);
		else if (count_r != '0)
			count_nxt = count_r - 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

	assign busy = (count_r != '0);
endmodule

// [hw/bcs_regs.sv]
// bcs_regs: control and status register bank of the battery booster.
// assumes a serial front end that turns bus frames into single-byte
// register reads and writes on core_clk, and a power-on reset.
//
// Overview of operation
// - set battery floor flag when battery dips below floor during Charge
// - battery floor flag stays set until power cycle
// - set capacitor warning flag when capacitor dips below warning in Active
// - capacitor warning drives ready pin low for the warning pulse time
// - output dip below set level in Active sets alarm, drives ready low
// - warning and alarm flags clear at start of next charging cycle
// - command bits: on-demand, continuous, force Active; 1 on, 0 off
// - writing 1 to command bit 3 resets optimizer of current slot
// - auto-run bit defaults 1 on I2C, 0 and unsettable on SPI
// - output level code bits 3:0, reset code 1001
// - fixed end-of-charge code bits 7:4, 0001 lowest to 1111 highest
// - fixed end-of-charge level used only when optimizer slot is zero
// - fixed end-of-charge code resets to 0000; host sets it for slot zero
// - storage ceiling bit 4: 0 lower ceiling default, 1 higher
// - battery floor code bits 2:0, default 000
`timescale 1ns/1ns
module bcs_regs #(
	parameter int EW_PULSE_CYCLES = bcs_pkg::T_EW_CYCLES
) (
	input wire logic core_clk, // core clock
	input wire logic reset, // power-on reset, synchronous, active high
	input wire logic reg_wr, // one-cycle write strobe
	input wire logic reg_rd, // one-cycle read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
	input wire logic spi_variant_pin, // strap: high on the SPI variant
	input wire logic charge_state, // state machine is in Charge
	input wire logic active_state, // state machine is in Active
	input wire logic charge_start, // one-cycle pulse: charging cycle begins
	input wire logic ready_ind, // ready indication from the state machine
	input wire logic batt_below_floor_pin, // battery_input_pin below floor
	input wire logic cap_below_warn_pin, // capacitor below warning level
	input wire logic out_below_set_pin, // regulated_output_pin below set
	input wire logic [3:0] opt_slot, // selected optimizer slot index
	input wire logic [3:0] learned_end_code, // optimizer end-of-charge code
	output logic ready_pin, // ready pin level, low on warning or alarm
	output bcs_pkg::bcs_levels_t levels, // programmed levels and controls
	output logic [3:0] charge_end_code, // end-of-charge code in use
	output logic opt_reset // one-cycle pulse: discard learned result
);
	bcs_pkg::bcs_state_t st_r;
	bcs_pkg::bcs_state_t st_nxt;
	bcs_pkg::bcs_cmp_t cmp;
	logic spi_variant;
	logic ew_window;
	logic cap_warn_event;
	logic [7:0] status_byte;

	initial begin
		if (EW_PULSE_CYCLES < 1)
			$error("bcs_regs: EW_PULSE_CYCLES must be at least 1");
	end

	bcs_sync2 #(
		.WIDTH(4)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({spi_variant_pin, batt_below_floor_pin,
			cap_below_warn_pin, out_below_set_pin}),
		.sync_out({spi_variant, cmp.batt_below_floor,
			cmp.cap_below_warn, cmp.out_below_set})
	);

	// start the low pulse on the entry into the warning condition
	assign cap_warn_event = active_state & cmp.cap_below_warn &
		~st_r.cap_below_d;

	bcs_pulse_timer #(
		.CYCLES(EW_PULSE_CYCLES)
	) u_ew_pulse (
		.core_clk(core_clk),
		.reset(reset),
		.start(cap_warn_event),
		.busy(ew_window)
	);

	assign ready_pin = ready_ind & ~ew_window & ~st_r.out_alarm_flag;

	always_comb begin
		status_byte = 8'h00;
		status_byte[bcs_pkg::STS_BATT_FLOOR_BIT] = st_r.batt_floor_flag;
		status_byte[bcs_pkg::STS_CAP_WARN_BIT] = st_r.cap_warn_flag;
		status_byte[bcs_pkg::STS_OUT_ALARM_BIT] = st_r.out_alarm_flag;
		status_byte[bcs_pkg::STS_READY_BIT] = ready_pin;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.opt_reset_pulse = 1'b0;
		st_nxt.cap_below_d = active_state & cmp.cap_below_warn;

		// strap is caught once the synchroniser has settled
		case (st_r.strap)
		bcs_pkg::BCS_STRAP_WAIT: begin
			if (st_r.strap_cnt == 2'(bcs_pkg::STRAP_SETTLE_CYCLES - 1)) begin
				st_nxt.strap = bcs_pkg::BCS_STRAP_DONE;
				st_nxt.lv.auto_run = ~spi_variant;
			end else begin
				st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
			end
		end
		bcs_pkg::BCS_STRAP_DONE: begin
			st_nxt.strap = bcs_pkg::BCS_STRAP_DONE;
		end
		default: begin
			st_nxt.strap = bcs_pkg::BCS_STRAP_WAIT;
		end
		endcase

		// writes; status and unmapped offsets are ignored
		if (reg_wr) begin
			case (reg_addr)
			bcs_pkg::OFS_RUN_COMMAND: begin
				st_nxt.lv.on_demand =
					reg_wdata[bcs_pkg::CMD_ON_DEMAND_BIT];
				st_nxt.lv.continuous =
					reg_wdata[bcs_pkg::CMD_CONTINUOUS_BIT];
				st_nxt.lv.force_active =
					reg_wdata[bcs_pkg::CMD_FORCE_ACTIVE_BIT];
				st_nxt.opt_reset_pulse =
					reg_wdata[bcs_pkg::CMD_OPT_RESET_BIT];
			end
			bcs_pkg::OFS_OUTPUT_AND_CHARGE_END_LEVELS: begin
				st_nxt.lv.vset = reg_wdata[bcs_pkg::VSET_LSB +: 4];
				st_nxt.lv.vfix = reg_wdata[bcs_pkg::VFIX_LSB +: 4];
			end
			bcs_pkg::OFS_BATTERY_FLOOR_SETTING: begin
				st_nxt.lv.vmin = reg_wdata[bcs_pkg::VMIN_LSB +: 3];
			end
			bcs_pkg::OFS_AUTO_RUN_SETTING: begin
				st_nxt.lv.auto_run = reg_wdata[bcs_pkg::AUTO_RUN_BIT] &
					~spi_variant;
			end
			bcs_pkg::OFS_STORAGE_CEILING_SETTING: begin
				st_nxt.lv.ceiling_high =
					reg_wdata[bcs_pkg::CEILING_BIT];
			end
			default: begin
			end
			endcase
		end

		// flags: clear first so that a coincident event wins
		if (charge_start) begin
			st_nxt.cap_warn_flag = 1'b0;
			st_nxt.out_alarm_flag = 1'b0;
		end
		if (charge_state & cmp.batt_below_floor)
			st_nxt.batt_floor_flag = 1'b1;
		if (active_state & cmp.cap_below_warn)
			st_nxt.cap_warn_flag = 1'b1;
		if (active_state & cmp.out_below_set)
			st_nxt.out_alarm_flag = 1'b1;

		// reads; unmapped offsets answer zero
		if (reg_rd) begin
			case (reg_addr)
			bcs_pkg::OFS_STATUS_FLAGS: st_nxt.rdata = status_byte;
			bcs_pkg::OFS_RUN_COMMAND: begin
				st_nxt.rdata = 8'h00;
				st_nxt.rdata[bcs_pkg::CMD_ON_DEMAND_BIT] = st_r.lv.on_demand;
				st_nxt.rdata[bcs_pkg::CMD_CONTINUOUS_BIT] =
					st_r.lv.continuous;
				st_nxt.rdata[bcs_pkg::CMD_FORCE_ACTIVE_BIT] =
					st_r.lv.force_active;
			end
			bcs_pkg::OFS_OUTPUT_AND_CHARGE_END_LEVELS:
				st_nxt.rdata = {st_r.lv.vfix, st_r.lv.vset};
			bcs_pkg::OFS_BATTERY_FLOOR_SETTING:
				st_nxt.rdata = {5'h00, st_r.lv.vmin};
			bcs_pkg::OFS_AUTO_RUN_SETTING:
				st_nxt.rdata = {st_r.lv.auto_run, 7'h00};
			bcs_pkg::OFS_STORAGE_CEILING_SETTING:
				st_nxt.rdata = {3'h0, st_r.lv.ceiling_high, 4'h0};
			default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_r.lv.vset <= bcs_pkg::VSET_RESET;
			st_r.lv.vfix <= bcs_pkg::VFIX_RESET;
			st_r.lv.vmin <= bcs_pkg::VMIN_RESET;
			st_r.lv.ceiling_high <= bcs_pkg::CEILING_RESET;
			st_r.lv.auto_run <= 1'b0;
			st_r.lv.on_demand <= 1'b0;
			st_r.lv.continuous <= 1'b0;
			st_r.lv.force_active <= 1'b0;
			st_r.batt_floor_flag <= 1'b0;
			st_r.cap_warn_flag <= 1'b0;
			st_r.out_alarm_flag <= 1'b0;
			st_r.cap_below_d <= 1'b0;
			st_r.opt_reset_pulse <= 1'b0;
			st_r.rdata <= 8'h00;
			st_r.strap <= bcs_pkg::BCS_STRAP_WAIT;
			st_r.strap_cnt <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign levels = st_r.lv;
	assign opt_reset = st_r.opt_reset_pulse;
	// fixed code applies only in fixed mode
	assign charge_end_code = (opt_slot == bcs_pkg::FIXED_SLOT) ?
		st_r.lv.vfix : learned_end_code;
endmodule

// [verif/bcs_regs_chk.sv]
// bcs_regs_chk: port checks for the register bank.
// assumes a bind into bcs_regs with the same pulse length.
`timescale 1ns/1ns
module bcs_regs_chk #(
	parameter int EW_PULSE_CYCLES = 4
) (
	input wire logic core_clk, // clock
	input wire logic reset, // reset
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_addr, // offset
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata, // read data
	input wire logic ready_pin, // ready pin
	input wire logic cap_below_warn_pin, // cap comparator
	input wire logic out_below_set_pin, // output comparator
	input wire logic active_state, // Active state
	input wire logic [3:0] opt_slot, // slot
	input wire logic [3:0] learned_end_code, // learned code
	input bcs_pkg::bcs_levels_t levels, // levels
	input wire logic [3:0] charge_end_code, // code in use
	input wire logic opt_reset // optimizer reset
);
	localparam int EW_LAST = EW_PULSE_CYCLES - 1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_wr(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_alarm;
		(active_state && out_below_set_pin)[*3];
	endsequence
	sequence s_warn;
		!cap_below_warn_pin ##1 (active_state && cap_below_warn_pin)[*3];
	endsequence
	property p_opt_reset;
		s_wr(8'h08) ##0 reg_wdata[3] |=> opt_reset;
	endproperty
	property p_opt_quiet;
		!(reg_wr && reg_addr == 8'h08 && reg_wdata[3]) |=> !opt_reset;
	endproperty
	property p_end_code;
		charge_end_code == (opt_slot == 4'h0 ? levels.vfix : learned_end_code);
	endproperty
	property p_output_and_charge_end_levels;
		s_wr(8'h09) |=> {levels.vfix, levels.vset} == $past(reg_wdata);
	endproperty
	property p_ceiling;
		s_wr(8'h0c) |=> levels.ceiling_high == $past(reg_wdata[4]);
	endproperty
	property p_status;
		s_rd(8'h00) |=> reg_rdata[4:0] == {4'h0, $past(ready_pin)};
	endproperty
	property p_cmd;
		s_wr(8'h08) ##2 s_rd(8'h08) |=>
			reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)};
	endproperty
	property p_alarm;
		s_alarm |=> !ready_pin;
	endproperty
	property p_warn;
		s_warn |=> !ready_pin ##EW_LAST !ready_pin;
	endproperty
	a_opt_reset: assert property (p_opt_reset)
		else $error("opt_reset pulse missing");
	a_opt_quiet: assert property (p_opt_quiet)
		else $error("opt_reset without cause");
	a_end_code: assert property (p_end_code)
		else $error("charge_end_code wrong");
	a_output_and_charge_end_levels: assert property (p_output_and_charge_end_levels)
		else $error("levels not taken from write");
	a_ceiling: assert property (p_ceiling)
		else $error("ceiling not taken from write");
	a_status: assert property (p_status)
		else $error("status low bits wrong");
	a_cmd: assert property (p_cmd)
		else $error("command readback wrong");
	a_alarm: assert property (p_alarm)
		else $error("ready_pin high during alarm");
	a_warn: assert property (p_warn)
		else $error("warning pulse wrong");
endmodule

// [verif/bcs_host.sv]
// bcs_host: host side of the register port, byte reads and writes.
// assumes strobes are sampled on the rising edge.
`timescale 1ns/1ns
module bcs_host (
	input wire logic core_clk, // clock
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_addr, // offset
	output logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata // read data
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// released lines flip so stale values are not trusted
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		// read data stands from the edge that took the strobe
		d = reg_rdata;
	endtask
endmodule

// [verif/bcs_regs_tb.sv]
// bcs_regs_tb: directed tests of the register bank.
// assumes bcs_pkg, bcs_regs, bcs_host and bcs_regs_chk are compiled.
`timescale 1ns/1ns
module bcs_regs_tb;
	localparam int EW = 4;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr, reg_rd, ready_pin, opt_reset;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic spi_variant_pin = 1'b0;
	logic charge_state = 1'b0;
	logic active_state = 1'b0;
	logic charge_start = 1'b0;
	logic ready_ind = 1'b1;
	logic batt = 1'b0;
	logic cap = 1'b0;
	logic outp = 1'b0;
	logic [3:0] opt_slot = 4'h0;
	logic [3:0] learned = 4'h3;
	logic [3:0] charge_end_code;
	bcs_pkg::bcs_levels_t levels;
	int err_count = 0;
	int compares = 0;
	always #5 core_clk = ~core_clk;
	bcs_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	bcs_regs #(.EW_PULSE_CYCLES(EW)) dut (.core_clk(core_clk),
		.reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.spi_variant_pin(spi_variant_pin), .charge_state(charge_state),
		.active_state(active_state), .charge_start(charge_start),
		.ready_ind(ready_ind), .batt_below_floor_pin(batt),
		.cap_below_warn_pin(cap), .out_below_set_pin(outp),
		.opt_slot(opt_slot), .learned_end_code(learned),
		.ready_pin(ready_pin), .levels(levels),
		.charge_end_code(charge_end_code), .opt_reset(opt_reset));
	task end_sim;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask
	task wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task pulse;
		@(negedge core_clk);
		charge_start = 1'b1;
		@(negedge core_clk);
		charge_start = 1'b0;
	endtask
	task t_defaults;
		rchk(8'h09, 8'h09);
		rchk(8'h0a, 8'h00);
		rchk(8'h0c, 8'h00);
		rchk(8'h0b, 8'h80);
		chk("auto_run", 8'h01, {7'h0, levels.auto_run});
		rchk(8'h08, 8'h00);
		$display("test defaults done");
	endtask
	task t_regs;
		host.wr(8'h09, 8'ha5);
		rchk(8'h09, 8'ha5);
		chk("end_code", 8'h0a, {4'h0, charge_end_code});
		@(negedge core_clk);
		opt_slot = 4'h1;
		#1 chk("end_code", 8'h03, {4'h0, charge_end_code});
		// only defined floor codes are written
		for (int i = 0; i < 5; i++) begin
			host.wr(8'h0a, 8'(i));
			rchk(8'h0a, 8'(i));
		end
		chk("vmin", 8'h04, {5'h0, levels.vmin});
		host.wr(8'h0c, 8'hff);
		rchk(8'h0c, 8'h10);
		host.wr(8'h08, 8'h0f);
		chk("opt_reset", 8'h01, {7'h0, opt_reset});
		chk("run_levels", 8'h07, {5'h0, levels.force_active,
			levels.continuous, levels.on_demand});
		rchk(8'h08, 8'h07);
		host.wr(8'h08, 8'h00);
		chk("opt_reset", 8'h00, {7'h0, opt_reset});
		host.wr(8'h00, 8'hff);
		rchk(8'h00, 8'h01);
		rchk(8'h0e, 8'h00);
		@(negedge core_clk);
		ready_ind = 1'b0;
		#1 chk("ready_pin", 8'h00, {7'h0, ready_pin});
		rchk(8'h00, 8'h00);
		ready_ind = 1'b1;
		$display("test registers done");
	endtask
	task t_flags;
		@(negedge core_clk);
		active_state = 1'b1;
		outp = 1'b1;
		wait_n(4);
		chk("ready_pin", 8'h00, {7'h0, ready_pin});
		rchk(8'h00, 8'h20);
		outp = 1'b0;
		wait_n(4);
		pulse();
		rchk(8'h00, 8'h01);
		@(negedge core_clk);
		cap = 1'b1;
		wait_n(4);
		chk("ready_pin", 8'h00, {7'h0, ready_pin});
		wait_n(5);
		chk("ready_pin", 8'h01, {7'h0, ready_pin});
		rchk(8'h00, 8'h41);
		active_state = 1'b0;
		cap = 1'b0;
		pulse();
		rchk(8'h00, 8'h01);
		charge_state = 1'b1;
		batt = 1'b1;
		wait_n(4);
		rchk(8'h00, 8'h81);
		charge_state = 1'b0;
		batt = 1'b0;
		pulse();
		wait_n(3);
		rchk(8'h00, 8'h81);
		$display("test flags done");
	endtask
	task t_spi;
		@(negedge core_clk);
		reset = 1'b1;
		spi_variant_pin = 1'b1;
		wait_n(2);
		reset = 1'b0;
		wait_n(5);
		rchk(8'h0b, 8'h00);
		host.wr(8'h0b, 8'h80);
		rchk(8'h0b, 8'h00);
		chk("auto_run", 8'h00, {7'h0, levels.auto_run});
		rchk(8'h00, 8'h01);
		$display("test strap done");
	endtask
	initial begin
		wait_n(2);
		reset = 1'b0;
		wait_n(5);
		t_defaults();
		t_regs();
		t_flags();
		t_spi();
		end_sim();
	end
	initial begin
		#100000;
		err_count++;
		end_sim();
	end
endmodule
bind bcs_regs bcs_regs_chk #(.EW_PULSE_CYCLES(EW_PULSE_CYCLES)) u_chk (
	.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.ready_pin(ready_pin), .cap_below_warn_pin(cap_below_warn_pin),
	.out_below_set_pin(out_below_set_pin), .active_state(active_state),
	.opt_slot(opt_slot), .learned_end_code(learned_end_code),
	.levels(levels), .charge_end_code(charge_end_code),
	.opt_reset(opt_reset));
